// ==== logic/region_protection_defines.vh ====
`ifndef REGION_PROTECTION_DEFINES_VH
`define REGION_PROTECTION_DEFINES_VH

// Register map on the private peripheral bus
`define RP_SELECT_ADDR     32'hE000_ED98
`define RP_MAP_SPAN        32'h0000_0024
`define RP_WORD_SELECT     4'h0
`define RP_BASE_OFFSET     32'h0000_0004
`define RP_SIZE_OFFSET     32'h0000_0008
`define RP_ATTR_OFFSET     32'h0000_000A

// Access sizes from the core
`define RP_SIZE_BYTE       2'h0
`define RP_SIZE_HALF       2'h1
`define RP_SIZE_WORD       2'h2

// Base register fields
`define RP_BASE_REGION_W   4
`define RP_BASE_VALID_BIT  4
`define RP_BASE_ADDR_LSB   5
`define RP_BASE_ADDR_W     27

// Attribute and size register fields
`define RP_ATTR_WMASK      32'h173F_FF3F
`define RP_ATTR_RESET      32'h0000_0000
`define RP_ATTR_ENABLE_BIT 0
`define RP_ATTR_SIZE_LSB   1
`define RP_ATTR_SRD_LSB    8
`define RP_ATTR_B_BIT      16
`define RP_ATTR_C_BIT      17
`define RP_ATTR_S_BIT      18
`define RP_ATTR_TEX_LSB    19
`define RP_ATTR_AP_LSB     24
`define RP_ATTR_XN_BIT     28

// Size field limits
`define RP_SIZE_MIN        5'h04
`define RP_SIZE_SUBREGION  5'h07
`define RP_SUB_SHIFT       5'h02

// Access permission codes
`define RP_AP_NONE         3'h0
`define RP_AP_PRIV_RW      3'h1
`define RP_AP_USER_RO      3'h2
`define RP_AP_FULL         3'h3
`define RP_AP_PRIV_RO      3'h5
`define RP_AP_RO           3'h6
`define RP_AP_RO_ALT       3'h7

// Fault status bit positions
`define RP_FS_IACC_BIT     0
`define RP_FS_DACC_BIT     1
`define RP_FS_ADDR_VALID   7

`endif

// ==== logic/region_table_mem.v ====
`timescale 1ns/100ps
`include "region_protection_defines.vh"

module region_table_mem #(
  parameter REGIONS = 8,
  parameter IDX_W   = 3
) (
  input  wire                                 clock_in,
  input  wire                                 resetn_in,
  input  wire                                 base_write_in,
  input  wire [3:0]                           attr_lanes_in,
  input  wire [IDX_W-1:0]                     write_index_in,
  input  wire [`RP_BASE_ADDR_W-1:0]           base_data_in,
  input  wire [31:0]                          attr_data_in,
  input  wire [IDX_W-1:0]                     read_index_in,
  output reg  [`RP_BASE_ADDR_W-1:0]           read_base_out,
  output reg  [31:0]                          read_attr_out,
  output wire [REGIONS*`RP_BASE_ADDR_W-1:0]   all_base_out,
  output wire [REGIONS*32-1:0]                all_attr_out
);

  reg [`RP_BASE_ADDR_W-1:0] base_mem [0:REGIONS-1];
  reg [31:0]                attr_mem [0:REGIONS-1];
  integer                   i;
  integer                   b;
  genvar                    g;

  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (i = 0; i < REGIONS; i = i + 1) begin
        base_mem[i] <= {`RP_BASE_ADDR_W{1'b0}};
        attr_mem[i] <= `RP_ATTR_RESET;
      end
      read_base_out <= {`RP_BASE_ADDR_W{1'b0}};
      read_attr_out <= `RP_ATTR_RESET;
    end else begin
      if (base_write_in) begin
        base_mem[write_index_in] <= base_data_in;
      end
      for (b = 0; b < 4; b = b + 1) begin
        if (attr_lanes_in[b]) begin
          attr_mem[write_index_in][b*8 +: 8] <= attr_data_in[b*8 +: 8];
        end
      end
      read_base_out <= base_mem[read_index_in];
      read_attr_out <= attr_mem[read_index_in];
    end
  end

  generate
    for (g = 0; g < REGIONS; g = g + 1) begin : flat
      assign all_base_out[g*`RP_BASE_ADDR_W +: `RP_BASE_ADDR_W] = base_mem[g];
      assign all_attr_out[g*32 +: 32] = attr_mem[g];
    end
  endgenerate

endmodule

// ==== logic/region_protection.v ====
`timescale 1ns/100ps
`include "region_protection_defines.vh"

module region_protection #(
  parameter REGIONS = 8,
  parameter IDX_W   = 3
) (
  input  wire             clock_in,
  input  wire             resetn_in,
  input  wire [31:0]      reg_addr_in,
  input  wire [31:0]      reg_wdata_in,
  input  wire [1:0]       reg_size_in,
  input  wire             reg_write_in,
  input  wire             reg_read_in,
  output reg  [31:0]      reg_rdata_out,
  output reg              reg_rvalid_out,
  input  wire             check_valid_in,
  input  wire [31:0]      check_addr_in,
  input  wire             check_priv_in,
  input  wire             check_write_in,
  input  wire             check_fetch_in,
  output reg              check_done_out,
  output reg              check_hit_out,
  output reg  [IDX_W-1:0] check_region_out,
  output reg  [9:0]       check_attr_out,
  output reg              mem_fault_out,
  input  wire             fault_status_clear_in,
  output reg  [7:0]       fault_status_out,
  output reg  [31:0]      fault_addr_out
);

  localparam KIND_SELECT = 3'b001;
  localparam KIND_BASE   = 3'b010;
  localparam KIND_ATTR   = 3'b100;
  localparam AW          = `RP_BASE_ADDR_W;

  // Byte lanes of an access; zero when it is misaligned
  function [3:0] lane_mask;
    input [1:0] low;
    input [1:0] size;
    begin
      lane_mask = 4'h0;
      if (size == `RP_SIZE_BYTE) begin
        lane_mask = 4'h1 << low;
      end else if (size == `RP_SIZE_HALF && !low[0]) begin
        lane_mask = low[1] ? 4'hC : 4'h3;
      end else if (size == `RP_SIZE_WORD && low == 2'h0) begin
        lane_mask = 4'hF;
      end
    end
  endfunction

  // Address lies inside a region of 2^(size+1) bytes
  function region_hit;
    input [31:0]   addr;
    input [AW-1:0] base;
    input [4:0]    size;
    reg   [32:0]   mask;
    begin
      mask = {33{1'b1}} << ({1'b0, size} + 6'd1);
      region_hit = ((addr ^ {base, {`RP_BASE_ADDR_LSB{1'b0}}})
                    & mask[31:0]) == 32'h0000_0000;
    end
  endfunction

  // Disabled-subregion test; small regions have none
  function sub_off;
    input [31:0] addr;
    input [4:0]  size;
    input [7:0]  subregion_disable_field;
    reg   [31:0] shifted;
    begin
      shifted = addr >> (size - `RP_SUB_SHIFT);
      sub_off = (size >= `RP_SIZE_SUBREGION) && subregion_disable_field[shifted[2:0]];
    end
  endfunction

  function ap_allows;
    input [2:0] ap;
    input       priv;
    input       write;
    begin
      case (ap)
        `RP_AP_PRIV_RW: ap_allows = priv;
        `RP_AP_USER_RO: ap_allows = priv | !write;
        `RP_AP_FULL:    ap_allows = 1'b1;
        `RP_AP_PRIV_RO: ap_allows = priv & !write;
        `RP_AP_RO:      ap_allows = !write;
        `RP_AP_RO_ALT:  ap_allows = !write;
        default:        ap_allows = 1'b0;
      endcase
    end
  endfunction

  reg  [IDX_W-1:0]         region_select_reg;
  reg  [2:0]               read_kind;
  reg  [1:0]               read_low;
  reg                      read_pending;
  wire [AW-1:0]            read_base;
  wire [31:0]              read_attr;
  wire [REGIONS*AW-1:0]    all_base;
  wire [REGIONS*32-1:0]    all_attr;

  // Register decode
  wire [31:0] offset = reg_addr_in - `RP_SELECT_ADDR;
  wire        in_map = offset < `RP_MAP_SPAN;
  wire [3:0]  word   = offset[5:2];
  wire [3:0]  lanes  = lane_mask(reg_addr_in[1:0], reg_size_in);
  wire        is_select = in_map && word == `RP_WORD_SELECT;
  wire        is_base   = in_map && word[0];
  wire        is_attr   = in_map && word != `RP_WORD_SELECT && !word[0];
  wire        word_acc  = lanes == 4'hF;
  wire        wr_ok     = reg_write_in && ((is_attr && lanes != 4'h0) ||
                          ((is_select || is_base) && word_acc));
  wire        rd_ok     = reg_read_in && in_map && lanes != 4'h0;
  wire        base_valid = reg_wdata_in[`RP_BASE_VALID_BIT];

  reg             next_base_write;
  reg [3:0]       next_attr_lanes;
  reg [IDX_W-1:0] next_write_index;

  always @* begin
    next_base_write  = 1'b0;
    next_attr_lanes  = 4'h0;
    next_write_index = region_select_reg;
    if (wr_ok && is_base) begin
      next_base_write = 1'b1;
      if (base_valid) begin
        next_write_index = reg_wdata_in[IDX_W-1:0];
      end
    end else if (wr_ok && is_attr) begin
      next_attr_lanes = lanes;
    end
  end

  // Writes land in the same edge they are issued, one per cycle
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      region_select_reg <= {IDX_W{1'b0}};
    end else if (wr_ok && is_select) begin
      region_select_reg <= reg_wdata_in[IDX_W-1:0];
    end else if (wr_ok && is_base && base_valid) begin
      region_select_reg <= reg_wdata_in[IDX_W-1:0];
    end
  end

  region_table_mem #(
    .REGIONS (REGIONS),
    .IDX_W   (IDX_W)
  ) table_mem (
    .clock_in       (clock_in),
    .resetn_in      (resetn_in),
    .base_write_in  (next_base_write),
    .attr_lanes_in  (next_attr_lanes),
    .write_index_in (next_write_index),
    .base_data_in   (reg_wdata_in[31:`RP_BASE_ADDR_LSB]),
    .attr_data_in   (reg_wdata_in & `RP_ATTR_WMASK),
    .read_index_in  (region_select_reg),
    .read_base_out  (read_base),
    .read_attr_out  (read_attr),
    .all_base_out   (all_base),
    .all_attr_out   (all_attr)
  );

  // Read path: table word registered, then formatted
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      read_kind      <= KIND_SELECT;
      read_low       <= 2'h0;
      read_pending   <= 1'b0;
      reg_rdata_out  <= 32'h0000_0000;
      reg_rvalid_out <= 1'b0;
    end else begin
      read_pending <= rd_ok;
      read_low     <= reg_addr_in[1:0];
      if (is_select) begin
        read_kind <= KIND_SELECT;
      end else if (is_base) begin
        read_kind <= KIND_BASE;
      end else begin
        read_kind <= KIND_ATTR;
      end
      reg_rvalid_out <= read_pending;
      if (read_pending) begin
        case (read_kind)
          KIND_SELECT: reg_rdata_out <= {{(32-IDX_W){1'b0}},
                                         region_select_reg};
          KIND_BASE:   reg_rdata_out <= {read_base, 1'b0,
                         {(`RP_BASE_VALID_BIT-IDX_W){1'b0}},
                         region_select_reg};
          KIND_ATTR:   reg_rdata_out <= read_attr;
          default:     reg_rdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Access check against all regions in parallel
  reg             found;
  reg [IDX_W-1:0] hit_index;
  reg [31:0]      hit_attr;
  reg [31:0]      attr_i;
  reg [AW-1:0]    base_i;
  integer         r;

  always @* begin
    found     = 1'b0;
    hit_index = {IDX_W{1'b0}};
    hit_attr  = 32'h0000_0000;
    attr_i    = 32'h0000_0000;
    base_i    = {AW{1'b0}};
    for (r = 0; r < REGIONS; r = r + 1) begin
      attr_i = all_attr[r*32 +: 32];
      base_i = all_base[r*AW +: AW];
      if (attr_i[`RP_ATTR_ENABLE_BIT] &&
          attr_i[`RP_ATTR_SIZE_LSB +: 5] >= `RP_SIZE_MIN &&
          region_hit(check_addr_in, base_i,
                     attr_i[`RP_ATTR_SIZE_LSB +: 5]) &&
          !sub_off(check_addr_in, attr_i[`RP_ATTR_SIZE_LSB +: 5],
                   attr_i[`RP_ATTR_SRD_LSB +: 8])) begin
        found     = 1'b1;
        hit_index = r[IDX_W-1:0];
        hit_attr  = attr_i;
      end
    end
  end

  wire permitted = found &&
       ap_allows(hit_attr[`RP_ATTR_AP_LSB +: 3], check_priv_in,
                 check_write_in) &&
       !(check_fetch_in && hit_attr[`RP_ATTR_XN_BIT]);
  wire violation = check_valid_in && !permitted;

  reg [7:0] next_status;

  always @* begin
    next_status = fault_status_out;
    if (fault_status_clear_in) begin
      next_status = 8'h00;
    end
    // A new fault outranks a clear in the same cycle
    if (violation) begin
      if (check_fetch_in) begin
        next_status[`RP_FS_IACC_BIT] = 1'b1;
      end else begin
        next_status[`RP_FS_DACC_BIT]   = 1'b1;
        next_status[`RP_FS_ADDR_VALID] = 1'b1;
      end
    end
  end

  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      check_done_out   <= 1'b0;
      check_hit_out    <= 1'b0;
      check_region_out <= {IDX_W{1'b0}};
      check_attr_out   <= 10'h000;
      mem_fault_out    <= 1'b0;
      fault_status_out <= 8'h00;
      fault_addr_out   <= 32'h0000_0000;
    end else begin
      check_done_out   <= check_valid_in;
      mem_fault_out    <= violation;
      fault_status_out <= next_status;
      if (check_valid_in) begin
        check_hit_out    <= found;
        check_region_out <= hit_index;
        check_attr_out   <= {hit_attr[`RP_ATTR_XN_BIT],
                             hit_attr[`RP_ATTR_AP_LSB +: 3],
                             hit_attr[`RP_ATTR_TEX_LSB +: 3],
                             hit_attr[`RP_ATTR_S_BIT],
                             hit_attr[`RP_ATTR_C_BIT],
                             hit_attr[`RP_ATTR_B_BIT]};
      end
      if (violation && !check_fetch_in) begin
        fault_addr_out <= check_addr_in;
      end
    end
  end

endmodule

// ==== tb/region_protection_monitor.sv ====
`timescale 1ns/100ps
`include "region_protection_defines.vh"
module region_protection_monitor #(
  parameter REGIONS = 8,
  parameter IDX_W   = 3
) (
  input wire             clock_in,
  input wire             resetn_in,
  input wire [31:0]      reg_addr_in,
  input wire [31:0]      reg_wdata_in,
  input wire [1:0]       reg_size_in,
  input wire             reg_write_in,
  input wire             reg_read_in,
  input wire [31:0]      reg_rdata_out,
  input wire             reg_rvalid_out,
  input wire             check_valid_in,
  input wire [31:0]      check_addr_in,
  input wire             check_priv_in,
  input wire             check_write_in,
  input wire             check_fetch_in,
  input wire             check_done_out,
  input wire             check_hit_out,
  input wire [IDX_W-1:0] check_region_out,
  input wire [9:0]       check_attr_out,
  input wire             mem_fault_out,
  input wire             fault_status_clear_in,
  input wire [7:0]       fault_status_out,
  input wire [31:0]      fault_addr_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  wire sel_rd = reg_read_in && reg_size_in == `RP_SIZE_WORD &&
                reg_addr_in == `RP_SELECT_ADDR;
  a_sel_read_ans: assert property (sel_rd |-> ##2 reg_rvalid_out)
    else $error("select read got no answer");
  a_rvalid_cause: assert property (
    reg_rvalid_out |-> $past(reg_read_in, 2))
    else $error("read answer without request");
  a_check_done: assert property (
    check_valid_in |=> check_done_out)
    else $error("check not answered");
  a_done_cause: assert property (
    check_done_out |-> $past(check_valid_in))
    else $error("check answer without request");
  a_miss_faults: assert property (
    check_done_out && !check_hit_out |-> mem_fault_out)
    else $error("miss without fault");
  a_fault_done: assert property (
    mem_fault_out |-> check_done_out)
    else $error("fault outside check answer");
  a_data_status: assert property (
    mem_fault_out && !$past(check_fetch_in)
    |-> fault_status_out[1] && fault_status_out[7])
    else $error("data fault not recorded");
  a_fetch_status: assert property (
    mem_fault_out && $past(check_fetch_in) |-> fault_status_out[0])
    else $error("fetch fault not recorded");
  a_fault_addr: assert property (
    mem_fault_out && !$past(check_fetch_in)
    |-> fault_addr_out == $past(check_addr_in))
    else $error("fault address wrong");
  a_status_sticky: assert property (
    fault_status_out[1] && !fault_status_clear_in |=> fault_status_out[1])
    else $error("status lost");
  c_fault: cover property (check_done_out && mem_fault_out);
  c_hit: cover property (check_done_out && check_hit_out);
  c_read: cover property (reg_rvalid_out);
endmodule

// ==== tb/core_model.sv ====
`timescale 1ns/100ps
module core_model (
  input  wire        clock_in,
  output reg  [31:0] addr_out,
  output reg  [31:0] wdata_out,
  output reg  [1:0]  size_out,
  output reg         write_out,
  output reg         read_out,
  output reg         cvalid_out,
  output reg  [31:0] caddr_out,
  output reg         cpriv_out,
  output reg         cwrite_out,
  output reg         cfetch_out,
  output reg         sclear_out
);
  initial begin
    {addr_out, wdata_out, size_out, write_out, read_out} = 0;
    {cvalid_out, caddr_out, cpriv_out, cwrite_out, cfetch_out} = 0;
    sclear_out = 0;
  end
  // One register access a call, in program order
  task acc(input [31:0] a, d, input [1:0] s, input w);
    begin
      @(posedge clock_in);
      #1;
      addr_out = a;
      wdata_out = d;
      size_out = s;
      write_out = w;
      read_out = !w;
      @(posedge clock_in);
      #1;
      write_out = 0;
      read_out = 0;
      addr_out = ~addr_out;
      wdata_out = ~wdata_out;
    end
  endtask
  // Checks start only after every earlier write has landed
  task check(input [31:0] a, input p, w, f);
    begin
      @(posedge clock_in);
      #1;
      {cvalid_out, caddr_out, cpriv_out, cwrite_out, cfetch_out} =
        {1'b1, a, p, w, f};
      @(posedge clock_in);
      #1;
      cvalid_out = 0;
      caddr_out = ~caddr_out;
    end
  endtask
  task clear;
    begin
      @(posedge clock_in);
      #1;
      sclear_out = 1;
      @(posedge clock_in);
      #1;
      sclear_out = 0;
    end
  endtask
endmodule

// ==== tb/region_protection_bench.sv ====
`timescale 1ns/100ps
`include "region_protection_defines.vh"
module region_protection_bench;
  localparam [31:0] A = `RP_SELECT_ADDR;
  reg         clock_in;
  reg         resetn_in;
  wire [31:0] reg_addr_in, reg_wdata_in, reg_rdata_out, check_addr_in;
  wire [31:0] fault_addr_out;
  wire [1:0]  reg_size_in;
  wire [2:0]  check_region_out;
  wire [9:0]  check_attr_out;
  wire [7:0]  fault_status_out;
  wire        reg_write_in, reg_read_in, reg_rvalid_out, check_valid_in;
  wire        check_priv_in, check_write_in, check_fetch_in, check_done_out;
  wire        check_hit_out, mem_fault_out, fault_status_clear_in;
  integer     bad_count, checks;
  core_model u_core (.clock_in(clock_in), .addr_out(reg_addr_in),
    .wdata_out(reg_wdata_in), .size_out(reg_size_in),
    .write_out(reg_write_in), .read_out(reg_read_in),
    .cvalid_out(check_valid_in), .caddr_out(check_addr_in),
    .cpriv_out(check_priv_in), .cwrite_out(check_write_in),
    .cfetch_out(check_fetch_in), .sclear_out(fault_status_clear_in));
  region_protection u_dut (.clock_in(clock_in), .resetn_in(resetn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_size_in(reg_size_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .check_valid_in(check_valid_in),
    .check_addr_in(check_addr_in), .check_priv_in(check_priv_in),
    .check_write_in(check_write_in), .check_fetch_in(check_fetch_in),
    .check_done_out(check_done_out), .check_hit_out(check_hit_out),
    .check_region_out(check_region_out), .check_attr_out(check_attr_out),
    .mem_fault_out(mem_fault_out), .fault_addr_out(fault_addr_out),
    .fault_status_clear_in(fault_status_clear_in),
    .fault_status_out(fault_status_out));
  always #50 clock_in = ~clock_in;
  task chk(input [35:0] s, e);
    begin
      checks = checks + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task wr(input [31:0] a, d, input [1:0] s);
    u_core.acc(a, d, s, 1'b1);
  endtask
  task rd(input [31:0] a, e);
    begin
      u_core.acc(a, 32'h0000_0000, 2'h2, 1'b0);
      @(posedge clock_in);
      #1;
      chk({reg_rvalid_out, reg_rdata_out}, {1'b1, e});
    end
  endtask
  // Expected {hit, region, fault}
  task ck(input [31:0] a, input w, f, input [4:0] e);
    begin
      u_core.check(a, 1'b1, w, f);
      chk({check_done_out, check_hit_out, check_region_out, mem_fault_out},
          {1'b1, e});
    end
  endtask
  task finish_test;
    begin
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    #100000;
    bad_count = bad_count + 1;
    finish_test;
  end
  initial begin
    {clock_in, resetn_in, bad_count, checks} = 0;
    repeat (8) @(posedge clock_in);
    #1;
    resetn_in = 1;
    rd(A, 32'h0000_0000);
    wr(A, 32'h0000_0002, 2'h2);
    wr(A + 4, 32'h2000_0000, 2'h2);
    wr(A + 8, 32'h0000_0011, 2'h1);
    wr(A + 10, 32'h0302_0000, 2'h1);
    rd(A + 4, 32'h2000_0002);
    rd(A + 8, 32'h0302_0011);
    ck(32'h2000_01FC, 0, 0, {1'b1, 3'h2, 1'b0});
    chk(check_attr_out, 10'h0C2);
    ck(32'h2000_0200, 0, 0, {1'b0, 3'h0, 1'b1});
    chk(fault_status_out, 8'h82);
    chk(fault_addr_out, 32'h2000_0200);
    $display("test region done");
    wr(A + 4, 32'h2000_0015, 2'h2);
    rd(A, 32'h0000_0005);
    wr(A + 8, 32'h0300_0111, 2'h2);
    ck(32'h2000_0000, 0, 0, {1'b1, 3'h2, 1'b0});
    ck(32'h2000_0040, 0, 0, {1'b1, 3'h5, 1'b0});
    wr(A + 9, 32'h0000_8000, 2'h0);
    wr(A + 9, 32'h0000_FF00, 2'h1);
    ck(32'h2000_0000, 0, 0, {1'b1, 3'h5, 1'b0});
    ck(32'h2000_01C0, 0, 0, {1'b1, 3'h2, 1'b0});
    wr(A, 32'h0000_0002, 2'h2);
    wr(A + 8, 32'h0000_0010, 2'h1);
    ck(32'h2000_01C0, 0, 0, {1'b0, 3'h0, 1'b1});
    wr(A, 32'h0000_0007, 2'h1);
    rd(A, 32'h0000_0002);
    $display("test subregion done");
    wr(A + 12, 32'h0000_0016, 2'h2);
    wr(A + 16, 32'hFFFF_00FF, 2'h2);
    rd(A, 32'h0000_0006);
    rd(A + 8, 32'h173F_003F);
    ck(32'h3000_0000, 1, 0, {1'b1, 3'h6, 1'b1});
    ck(32'h3000_0000, 0, 0, {1'b1, 3'h6, 1'b0});
    ck(32'h3000_0000, 0, 1, {1'b1, 3'h6, 1'b1});
    chk(fault_status_out, 8'h83);
    u_core.clear;
    chk(fault_status_out, 8'h00);
    $display("test alias done");
    finish_test;
  end
endmodule
bind region_protection region_protection_monitor #(.REGIONS(REGIONS),
  .IDX_W(IDX_W)) u_mon (.clock_in(clock_in), .resetn_in(resetn_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_size_in(reg_size_in), .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .check_valid_in(check_valid_in),
  .check_addr_in(check_addr_in), .check_priv_in(check_priv_in),
  .check_write_in(check_write_in), .check_fetch_in(check_fetch_in),
  .check_done_out(check_done_out), .check_hit_out(check_hit_out),
  .check_region_out(check_region_out), .check_attr_out(check_attr_out),
  .mem_fault_out(mem_fault_out), .fault_addr_out(fault_addr_out),
  .fault_status_clear_in(fault_status_clear_in),
  .fault_status_out(fault_status_out));
